// ---- logic/asc_consts.vh ----
// Purpose: constants for the asynchronous static memory controller
// Assumes: 25 MHz system clock, slower (70 ns) memory speed grade timing
// Notes:   cycle counts round minimum times up to whole clock periods
`ifndef ASC_CONSTS_VH
`define ASC_CONSTS_VH

// ----------------------------------------------------------------------------
// geometry
// ----------------------------------------------------------------------------
`define ASC_ADDR_W 17
`define ASC_DATA_W 16
`define ASC_WORDS 131072
`define ASC_LANE_LO 0
`define ASC_LANE_HI 1

// ----------------------------------------------------------------------------
// pin active and idle levels
// ----------------------------------------------------------------------------
`define ASC_PIN_OFF 1'h1
`define ASC_PIN_ON 1'h0
`define ASC_ADDR_RST 17'h00000
`define ASC_DATA_RST 16'h0000

// ----------------------------------------------------------------------------
// timing in ns (70 ns grade) and derived cycle counts
// ----------------------------------------------------------------------------
`define ASC_CLK_PERIOD_NS 40
`define ASC_T_CW_NS 60
`define ASC_T_AW_NS 60
`define ASC_T_BW_NS 60
`define ASC_T_WP_NS 55
`define ASC_T_AA_NS 70
`define ASC_T_OE_NS 35
`define ASC_T_HZ_NS 25
`define ASC_T_OW_NS 10
`define ASC_CEIL_CYC(ns) (((ns) + `ASC_CLK_PERIOD_NS - 1) / `ASC_CLK_PERIOD_NS)
`define ASC_WP_CYC `ASC_CEIL_CYC(`ASC_T_WP_NS)
`define ASC_CW_CYC `ASC_CEIL_CYC(`ASC_T_CW_NS)
`define ASC_RD_CYC `ASC_CEIL_CYC(`ASC_T_AA_NS)
`define ASC_HZ_CYC `ASC_CEIL_CYC(`ASC_T_HZ_NS)
`define ASC_TMR_W 4

`endif

// ---- logic/asc_ctrl.v ----
// Purpose: host controller driving a 128K x 16 asynchronous static memory
// Assumes: pin inputs synchronous to clk_sys; 70 ns memory grade at 25 MHz
// Notes:   one access at a time; output gate only low during reads
//
// Behaviour
// - controller never drives opposite data while memory may drive lines
// - chip select low at least 60 ns before write end
// - address valid at least 60 ns before write end
// - lane select low at least 60 ns before write end
`timescale 1ns/1ps
`include "asc_consts.vh"

module asc_ctrl (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // user request
  input wire req_valid,
  input wire req_write,
  input wire [`ASC_ADDR_W-1:0] req_addr,
  input wire [`ASC_DATA_W-1:0] req_wdata,
  input wire [1:0] req_lane_en,
  output wire req_ready,
  // user response
  output wire rsp_valid,
  output wire [`ASC_DATA_W-1:0] rsp_rdata,
  // memory control pins
  output wire [`ASC_ADDR_W-1:0] word_address,
  output wire chip_select_n,
  output wire write_strobe_n,
  output wire output_gate_n,
  output wire low_byte_sel_n,
  output wire high_byte_sel_n,
  // memory data pins
  input wire [`ASC_DATA_W-1:0] data_lines_in,
  output wire [`ASC_DATA_W-1:0] data_lines_out,
  output wire data_lines_oe
);

  // ----------------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WR_SETUP = 3'h1;
  localparam [2:0] ST_WR_PULSE = 3'h2;
  localparam [2:0] ST_WR_HOLD = 3'h3;
  localparam [2:0] ST_RD_WAIT = 3'h4;
  localparam [2:0] ST_TURN = 3'h5;

  // cycle counts cut to the timer width on purpose; all fit easily
  localparam integer WP_CYC = `ASC_WP_CYC;
  localparam integer RD_CYC = `ASC_RD_CYC;
  localparam integer HZ_CYC = `ASC_HZ_CYC;
  localparam [`ASC_TMR_W-1:0] ONE_TICK = {{(`ASC_TMR_W-1){1'b0}}, 1'b1};
  localparam [`ASC_TMR_W-1:0] WP_LOAD = WP_CYC[`ASC_TMR_W-1:0] - ONE_TICK;
  localparam [`ASC_TMR_W-1:0] RD_LOAD = RD_CYC[`ASC_TMR_W-1:0] - ONE_TICK;
  localparam [`ASC_TMR_W-1:0] HZ_LOAD = HZ_CYC[`ASC_TMR_W-1:0] - ONE_TICK;

  // lane enable (active high) to active-low lane select pin
  function lane_pin;
    input en;
    begin
      lane_pin = en ? `ASC_PIN_ON : `ASC_PIN_OFF;
    end
  endfunction

  reg [2:0] state_reg, state_next;
  reg [`ASC_ADDR_W-1:0] addr_reg, addr_next;
  reg [`ASC_DATA_W-1:0] wdata_reg, wdata_next;
  reg [`ASC_DATA_W-1:0] rdata_reg, rdata_next;
  reg [1:0] lane_reg, lane_next;
  reg cs_reg, cs_next;
  reg we_reg, we_next;
  reg oe_reg, oe_next;
  reg dq_oe_reg, dq_oe_next;
  reg ready_reg, ready_next;
  reg rsp_valid_reg, rsp_valid_next;
  reg tmr_load;
  reg [`ASC_TMR_W-1:0] tmr_val;
  wire tmr_done;
  wire [1:0] lane_pins;
  reg [1:0] lane_sel_n_reg;

  // ----------------------------------------------------------------------------
  // phase timer
  // ----------------------------------------------------------------------------
  asc_timer u_timer (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_done)
  );

  // ----------------------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------------------
  // next-state and pin levels for each phase
  always @* begin
    state_next = state_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    lane_next = lane_reg;
    cs_next = cs_reg;
    we_next = we_reg;
    oe_next = oe_reg;
    dq_oe_next = dq_oe_reg;
    ready_next = ready_reg;
    rsp_valid_next = 1'b0;
    tmr_load = 1'b0;
    tmr_val = {`ASC_TMR_W{1'b0}};
    case (state_reg)
      ST_IDLE: begin
        if (req_valid && ready_reg && (req_lane_en != 2'h0)) begin
          // address, select and lanes go out together
          addr_next = req_addr;
          lane_next = req_lane_en;
          cs_next = `ASC_PIN_ON;
          ready_next = 1'b0;
          if (req_write) begin
            // gate stays high so the memory never drives during a write
            wdata_next = req_wdata;
            oe_next = `ASC_PIN_OFF;
            dq_oe_next = 1'b1;
            state_next = ST_WR_SETUP;
          end else begin
            oe_next = `ASC_PIN_ON;
            dq_oe_next = 1'b0;
            tmr_load = 1'b1;
            tmr_val = RD_LOAD;
            state_next = ST_RD_WAIT;
          end
        end
      end
      ST_WR_SETUP: begin
        // select already low before the strobe falls
        we_next = `ASC_PIN_ON;
        tmr_load = 1'b1;
        tmr_val = WP_LOAD;
        state_next = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        if (tmr_done) begin
          // strobe, select and lanes rise together to end the write
          we_next = `ASC_PIN_OFF;
          cs_next = `ASC_PIN_OFF;
          lane_next = 2'h0;
          state_next = ST_WR_HOLD;
        end
      end
      ST_WR_HOLD: begin
        // data held one cycle past the write end, then released
        dq_oe_next = 1'b0;
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
      ST_RD_WAIT: begin
        if (tmr_done) begin
          // address and gate access time both covered here
          rdata_next = data_lines_in;
          rsp_valid_next = 1'b1;
          cs_next = `ASC_PIN_OFF;
          oe_next = `ASC_PIN_OFF;
          lane_next = 2'h0;
          tmr_load = 1'b1;
          tmr_val = HZ_LOAD;
          state_next = ST_TURN;
        end
      end
      ST_TURN: begin
        // bus turnaround: memory must release before anyone drives again
        if (tmr_done) begin
          ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: begin
        cs_next = `ASC_PIN_OFF;
        we_next = `ASC_PIN_OFF;
        oe_next = `ASC_PIN_OFF;
        dq_oe_next = 1'b0;
        lane_next = 2'h0;
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  // all pins idle deselected after reset
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      addr_reg <= `ASC_ADDR_RST;
      wdata_reg <= `ASC_DATA_RST;
      rdata_reg <= `ASC_DATA_RST;
      lane_reg <= 2'h0;
      lane_sel_n_reg <= {2{`ASC_PIN_OFF}};
      cs_reg <= `ASC_PIN_OFF;
      we_reg <= `ASC_PIN_OFF;
      oe_reg <= `ASC_PIN_OFF;
      dq_oe_reg <= 1'b0;
      ready_reg <= 1'b1;
      rsp_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      lane_reg <= lane_next;
      lane_sel_n_reg <= lane_pins;
      cs_reg <= cs_next;
      we_reg <= we_next;
      oe_reg <= oe_next;
      dq_oe_reg <= dq_oe_next;
      ready_reg <= ready_next;
      rsp_valid_reg <= rsp_valid_next;
    end
  end

  // ----------------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------------
  // next pin level of each lane select, registered so the pins leave a flop
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_lane
      assign lane_pins[gi] = lane_pin(lane_next[gi]);
    end
  endgenerate

  // all outputs straight from flip-flops
  assign word_address = addr_reg;
  assign chip_select_n = cs_reg;
  assign write_strobe_n = we_reg;
  assign output_gate_n = oe_reg;
  assign low_byte_sel_n = lane_sel_n_reg[`ASC_LANE_LO];
  assign high_byte_sel_n = lane_sel_n_reg[`ASC_LANE_HI];
  assign data_lines_out = wdata_reg;
  assign data_lines_oe = dq_oe_reg;
  assign req_ready = ready_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_rdata = rdata_reg;

endmodule // asc_ctrl

// ---- logic/asc_timer.v ----
// Purpose: down counter that times the phases of a memory access
// Assumes: load has priority over counting
// Notes:   expired is high once the loaded count has run down to zero
`timescale 1ns/1ps
`include "asc_consts.vh"

module asc_timer (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // control
  input wire load,
  input wire [`ASC_TMR_W-1:0] load_val,
  // status
  output wire expired
);

  reg [`ASC_TMR_W-1:0] count_reg;
  reg [`ASC_TMR_W-1:0] count_next;

  // ----------------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------------
  // next count: load, else step down to zero
  always @* begin
    count_next = count_reg;
    if (load) begin
      count_next = load_val;
    end else if (count_reg != {`ASC_TMR_W{1'b0}}) begin
      count_next = count_reg - {{(`ASC_TMR_W-1){1'b0}}, 1'b1};
    end
  end

  // state register
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      count_reg <= {`ASC_TMR_W{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end

  // done flag
  assign expired = (count_reg == {`ASC_TMR_W{1'b0}});

endmodule // asc_timer

// ---- verif/asc_ctrl_checker.sv ----
// Purpose: pin timing checks for the memory controller
// Assumes: 40 ns clock
// Notes:   bound to asc_ctrl
`timescale 1ns/1ps
module asc_ctrl_checker (
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // user side
  input wire rsp_valid,
  input wire [15:0] rsp_rdata,
  // memory pins
  input wire [16:0] word_address,
  input wire chip_select_n,
  input wire write_strobe_n,
  input wire output_gate_n,
  input wire low_byte_sel_n,
  input wire high_byte_sel_n,
  input wire [15:0] data_lines_in,
  input wire [15:0] data_lines_out,
  input wire data_lines_oe
);
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // enabled lanes as a bit mask
  wire [15:0] lane_m = {{8{~high_byte_sel_n}}, {8{~low_byte_sel_n}}};
  // steps of a write and of a read
  sequence s_wr;
    (!chip_select_n && !write_strobe_n && output_gate_n) [*2] ##1 (chip_select_n && write_strobe_n);
  endsequence
  sequence s_rd;
    (!chip_select_n && !output_gate_n && write_strobe_n) [*2] ##1 (rsp_valid && chip_select_n && output_gate_n);
  endsequence
  property p_wr; $fell(write_strobe_n) |-> s_wr; endproperty
  a_wr: assert property (p_wr) else $error("write pulse wrong");
  property p_rd; $fell(output_gate_n) |-> s_rd; endproperty
  a_rd: assert property (p_rd) else $error("read cycle wrong");
  property p_cs; $rose(write_strobe_n) |-> !$past(chip_select_n, 1) && !$past(chip_select_n, 2); endproperty
  a_cs: assert property (p_cs) else $error("select too short");
  property p_cs_first; $fell(write_strobe_n) |-> !$past(chip_select_n, 1); endproperty
  a_cs_first: assert property (p_cs_first) else $error("select not ahead of strobe");
  property p_adr; $rose(write_strobe_n) |-> $past(word_address, 1) == $past(word_address, 2); endproperty
  a_adr: assert property (p_adr) else $error("address unsteady");
  property p_lane; $rose(write_strobe_n) |-> $past(lane_m, 1) == $past(lane_m, 2) && $past(lane_m, 1) != 16'h0000;
  endproperty
  a_lane: assert property (p_lane) else $error("lane select too short");
  property p_oe; data_lines_oe |-> output_gate_n; endproperty
  a_oe: assert property (p_oe) else $error("bus contention");
  property p_wd; !write_strobe_n |-> data_lines_oe && $stable(data_lines_out); endproperty
  a_wd: assert property (p_wd) else $error("write data unsteady");
  property p_rdat; rsp_valid |-> (rsp_rdata & $past(lane_m)) == ($past(data_lines_in) & $past(lane_m)); endproperty
  a_rdat: assert property (p_rdat) else $error("read data wrong");
endmodule // asc_ctrl_checker

bind asc_ctrl asc_ctrl_checker i_chk (.clk_sys, .rst_b, .rsp_valid, .rsp_rdata, .word_address, .chip_select_n,
  .write_strobe_n, .output_gate_n, .low_byte_sel_n, .high_byte_sel_n, .data_lines_in, .data_lines_out, .data_lines_oe);

// ---- verif/asc_ctrl_tb.sv ----
// Purpose: self-checking bench for the memory controller
// Assumes: behavioural memory on the pins
// Notes:   corners, lane merges, seeded random traffic
`timescale 1ns/1ps
module asc_ctrl_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [16:0] req_addr = 17'h00000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0] req_lane_en = 2'h0;
  wire req_ready, rsp_valid, chip_select_n, write_strobe_n, output_gate_n, low_byte_sel_n, high_byte_sel_n;
  wire data_lines_oe;
  wire [15:0] rsp_rdata, data_lines_out, mem_dq;
  wire [16:0] word_address;
  wire [15:0] data_lines_in = data_lines_oe ? data_lines_out : mem_dq;
  wire [7:0] pins = {chip_select_n, write_strobe_n, output_gate_n, low_byte_sel_n, high_byte_sel_n,
    data_lines_oe, req_ready, rsp_valid};
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 32'ha74a81b1;
  logic [15:0] shadow [int];
  logic [31:0] r;
  logic [16:0] a;
  // design and memory
  asc_ctrl i_dut (.clk_sys, .rst_b, .req_valid, .req_write, .req_addr, .req_wdata, .req_lane_en, .req_ready,
    .rsp_valid, .rsp_rdata, .word_address, .chip_select_n, .write_strobe_n, .output_gate_n, .low_byte_sel_n,
    .high_byte_sel_n, .data_lines_in, .data_lines_out, .data_lines_oe);
  asc_sram_model i_mem (.word_address, .chip_select_n, .write_strobe_n, .output_gate_n, .low_byte_sel_n,
    .high_byte_sel_n, .dq_in(data_lines_out), .dq_out(mem_dq));
  initial forever #20 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      failures++;
      end_sim();
    end
  end
  function automatic logic [15:0] lm(input logic [1:0] ln);
    return {{8{ln[1]}}, {8{ln[0]}}};
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one access: hold until taken, then await the answer of a read
  task automatic xfer(input logic w, input logic [16:0] ad, input logic [15:0] d, input logic [1:0] ln);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= d;
    req_lane_en <= ln;
    do @(posedge clk_sys); while (req_ready !== 1'b1 && ++n < 9);
    req_valid <= 1'b0;
    do @(posedge clk_sys); while (!w && rsp_valid !== 1'b1 && ++n < 18);
    check("handshake", 16'(n < 9), 16'h0001);
    if (w) shadow[ad] = (shadow[ad] & ~lm(ln)) | (d & lm(ln));
    else check("rdata", rsp_rdata & lm(ln), shadow[ad] & lm(ln));
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    check("idle", {8'h00, pins}, 16'h00fa);
    // no lane enabled: never taken
    req_valid <= 1'b1;
    repeat (3) @(posedge clk_sys);
    check("refused", {14'h0000, chip_select_n, req_ready}, 16'h0003);
    req_valid <= 1'b0;
    @(posedge clk_sys);
    // array ends with single-lane merges
    for (int i = 0; i < 2; i++) begin
      a = i ? 17'h1ffff : 17'h00000;
      xfer(1'b1, a, 16'hc3a5 ^ {16{i[0]}}, 2'h3);
      xfer(1'b1, a, 16'h5a11 ^ {16{i[0]}}, 2'h1);
      xfer(1'b1, a, 16'h77e0 ^ {16{i[0]}}, 2'h2);
      for (int k = 1; k < 4; k++) xfer(1'b0, a, 16'h0000, k[1:0]);
    end
    // both ends hold different words: aliased address lines show here
    xfer(1'b0, 17'h00000, 16'h0000, 2'h3);
    // seeded random traffic on a small pool
    for (int i = 0; i < 8; i++) xfer(1'b1, {14'h0020, i[2:0]}, 16'h1000 + i[15:0], 2'h3);
    for (int i = 0; i < 80; i++) begin
      r = $random(seed);
      xfer(r[5], {14'h0020, r[4:2]}, r[31:16], r[1:0] == 2'h0 ? 2'h3 : r[1:0]);
    end
    end_sim();
  end
endmodule // asc_ctrl_tb

// ---- verif/asc_sram_model.sv ----
// Purpose: behavioural 128K x 16 static memory
// Assumes: pins straight from the controller
// Notes:   unwritten words read unknown
`timescale 1ns/1ps
module asc_sram_model (
  // pins
  input wire [16:0] word_address,
  input wire chip_select_n,
  input wire write_strobe_n,
  input wire output_gate_n,
  input wire low_byte_sel_n,
  input wire high_byte_sel_n,
  input wire [15:0] dq_in,
  output logic [15:0] dq_out
);
  logic [15:0] mem [int];
  logic [15:0] rd;
  logic [1:0] ln;
  initial dq_out = 16'h0ff0;
  // store on selected strobe, drive on gated read, idle lanes toggle
  always @(word_address, chip_select_n, write_strobe_n, output_gate_n, low_byte_sel_n, high_byte_sel_n, dq_in) begin
    ln = ~{high_byte_sel_n, low_byte_sel_n};
    rd = mem.exists(word_address) ? mem[word_address] : 16'hxxxx;
    for (int i = 0; i < 2; i++) begin
      if (!chip_select_n && !write_strobe_n && ln[i]) rd[8*i+:8] = dq_in[8*i+:8];
      if (!chip_select_n && write_strobe_n && !output_gate_n && ln[i]) dq_out[8*i+:8] = rd[8*i+:8];
      else dq_out[8*i+:8] = ~dq_out[8*i+:8];
    end
    if (!chip_select_n && !write_strobe_n && ln != 2'h0) mem[word_address] = rd;
  end
endmodule // asc_sram_model
